// File: verilog/agc_defs.svh
// register offsets, field positions, reset values and codes of the analog gain control block
`ifndef AGC_DEFS_SVH
`define AGC_DEFS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define AGC_OFS_CAPABILITY 8'h00
`define AGC_OFS_ALL_COLOR 8'h04
`define AGC_OFS_GREEN_ON_RED 8'h08
`define AGC_OFS_RED 8'h0C
`define AGC_OFS_BLUE 8'h10
`define AGC_OFS_GREEN_ON_BLUE 8'h14
`define AGC_OFS_STATUS 8'h18
`define AGC_OFS_CONTROL 8'h1C

// ----------------------------------------------------------------
// field layout of a gain word
// ----------------------------------------------------------------
`define AGC_DIG_HI 15
`define AGC_DIG_LO 12
`define AGC_COL_HI 11
`define AGC_COL_LO 10
`define AGC_SS_HI 9
`define AGC_SS_LO 8
`define AGC_RSVD_BIT 7
`define AGC_FINE_HI 6
`define AGC_FINE_LO 0
`define AGC_WRITE_MASK 16'hFF7F

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define AGC_GAIN_RESET 16'h1050
`define AGC_CAPABILITY_VALUE 16'h0001
`define AGC_CONTROL_RESET 1'b0
// factors in 1/32 units; second stage 1.3x held as 42/32
`define AGC_SS_X1 8'h20
`define AGC_SS_X13 8'h2A
`define AGC_SS_X2 8'h40
`define AGC_SS_X4 8'h80
`define AGC_RESP_OKAY 2'b00
`define AGC_RESP_SLVERR 2'b10

`endif

// File: verilog/agc_pkg.sv
// types shared by the analog gain control block
package agc_pkg;

  // colour channel index into the gain arrays
  typedef enum logic [1:0] {
    AGC_CH_GREEN_ON_RED,
    AGC_CH_RED,
    AGC_CH_BLUE,
    AGC_CH_GREEN_ON_BLUE
  } agc_channel_t;

  typedef logic [3:0][15:0] agc_word_array_t;

  // complete state of the block
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    agc_word_array_t gain;
    agc_word_array_t applied;
    agc_word_array_t total;
    logic update_pending;
    logic immediate_apply;
    logic [15:0] frames_applied;
    logic sync_1;
    logic sync_2;
    logic sync_3;
  } agc_state_t;

endpackage

// File: verilog/agc_top.sv
// analog gain control register bank with AXI4-Lite slave and frame-aligned apply
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "agc_defs.svh"

module agc_top
  import agc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_start,
  output logic [3:0][15:0] applied_gain_word,
  output logic [3:0][3:0] digital_multiplier,
  output logic [3:0][15:0] analog_gain_x1024,
  output logic update_pending
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // column factor as a plain integer multiplier
  function automatic logic [2:0] col_factor(input logic [1:0] code);
    logic [2:0] f;
    f = 3'h1;
    unique case (code)
      2'b00: f = 3'h1;
      2'b01: f = 3'h3;
      2'b10: f = 3'h2;
      2'b11: f = 3'h4;
    endcase
    return f;
  endfunction

  // second-stage factor in 1/32 units; 1.3x cannot be exact in 1/32 steps
  function automatic logic [7:0] second_stage_factor(input logic [1:0] code);
    logic [7:0] f;
    f = `AGC_SS_X1;
    unique case (code)
      2'b00: f = `AGC_SS_X1;
      2'b01: f = `AGC_SS_X13;
      2'b10: f = `AGC_SS_X2;
      2'b11: f = `AGC_SS_X4;
    endcase
    return f;
  endfunction

  // total analog gain in 1/1024 units: col * ss/32 * fine/32
  function automatic logic [15:0] total_gain(input logic [15:0] word);
    logic [2:0] c;
    logic [7:0] s;
    logic [6:0] fine;
    logic [17:0] prod;
    c = col_factor(word[`AGC_COL_HI:`AGC_COL_LO]);
    s = second_stage_factor(word[`AGC_SS_HI:`AGC_SS_LO]);
    fine = word[`AGC_FINE_HI:`AGC_FINE_LO];
    prod = 18'(c) * 18'(s) * 18'(fine);
    return prod[15:0];
  endfunction

  // address decode used by both the write and the read path
  function automatic logic is_gain_word(input logic [7:0] a);
    return (a == `AGC_OFS_GREEN_ON_RED) || (a == `AGC_OFS_RED) ||
           (a == `AGC_OFS_BLUE) || (a == `AGC_OFS_GREEN_ON_BLUE);
  endfunction

  function automatic logic [1:0] gain_index(input logic [7:0] a);
    logic [1:0] i;
    i = 2'(AGC_CH_GREEN_ON_RED);
    unique case (a)
      `AGC_OFS_RED: i = 2'(AGC_CH_RED);
      `AGC_OFS_BLUE: i = 2'(AGC_CH_BLUE);
      `AGC_OFS_GREEN_ON_BLUE: i = 2'(AGC_CH_GREEN_ON_BLUE);
      default: i = 2'(AGC_CH_GREEN_ON_RED);
    endcase
    return i;
  endfunction

  // merge a write into a 16-bit word under byte strobes
  function automatic logic [15:0] merge_word(input logic [15:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = data[7:0];
    end
    if (strb[1]) begin
      m[15:8] = data[15:8];
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  agc_state_t q;
  agc_state_t d;

  logic do_write;
  logic do_read;
  logic frame_edge;
  logic apply_now;
  logic gain_written;

  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready = !q.w_held && !q.bvalid;
  assign s_axi_arready = !q.rvalid;

  always_comb begin
    d = q;
    gain_written = 1'b0;

    // frame pin comes from the sensor timing domain
    d.sync_1 = frame_start;
    d.sync_2 = q.sync_1;
    d.sync_3 = q.sync_2;
    frame_edge = q.sync_2 && !q.sync_3;

    // ----------------------------------------------------------------
    // write channel: address and data taken in either order
    // ----------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_held = 1'b1;
      d.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_held = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end

    do_write = q.aw_held && q.w_held && !q.bvalid;
    if (do_write) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `AGC_RESP_OKAY;
      if (q.awaddr == `AGC_OFS_ALL_COLOR) begin
        for (int i = 0; i < 4; i++) begin
          // reserved bit held at zero whatever is written
          d.gain[i] = merge_word(q.gain[i], q.wdata, q.wstrb) & `AGC_WRITE_MASK;
        end
        gain_written = 1'b1;
      end else if (is_gain_word(q.awaddr)) begin
        d.gain[gain_index(q.awaddr)] =
          merge_word(q.gain[gain_index(q.awaddr)], q.wdata, q.wstrb) & `AGC_WRITE_MASK;
        gain_written = 1'b1;
      end else if (q.awaddr == `AGC_OFS_CONTROL) begin
        if (q.wstrb[0]) begin
          d.immediate_apply = q.wdata[0];
        end
      end else if (q.awaddr == `AGC_OFS_CAPABILITY || q.awaddr == `AGC_OFS_STATUS) begin
        // read-only words: write ignored, answered normally
        d.bresp = `AGC_RESP_OKAY;
      end else begin
        d.bresp = `AGC_RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // read channel: answer one cycle after the address is taken
    // ----------------------------------------------------------------
    do_read = s_axi_arvalid && s_axi_arready;
    if (do_read) begin
      d.rvalid = 1'b1;
      d.rresp = `AGC_RESP_OKAY;
      d.rdata = 32'h0000_0000;
      if (s_axi_araddr[7:0] == `AGC_OFS_CAPABILITY) begin
        d.rdata[15:0] = `AGC_CAPABILITY_VALUE;
      end else if (s_axi_araddr[7:0] == `AGC_OFS_ALL_COLOR) begin
        // no storage of its own: mirrors the green-on-red word
        d.rdata[15:0] = q.gain[AGC_CH_GREEN_ON_RED];
      end else if (is_gain_word(s_axi_araddr[7:0])) begin
        d.rdata[15:0] = q.gain[gain_index(s_axi_araddr[7:0])];
      end else if (s_axi_araddr[7:0] == `AGC_OFS_STATUS) begin
        d.rdata[0] = q.update_pending;
        d.rdata[31:16] = q.frames_applied;
      end else if (s_axi_araddr[7:0] == `AGC_OFS_CONTROL) begin
        d.rdata[0] = q.immediate_apply;
      end else begin
        d.rresp = `AGC_RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // frame-aligned apply
    // ----------------------------------------------------------------
    // pending gain words are applied on a frame edge, or in any cycle while immediate_apply is set
    apply_now = q.update_pending && (frame_edge || q.immediate_apply);
    if (apply_now) begin
      d.applied = q.gain;
      d.frames_applied = q.frames_applied + 16'h0001;
      for (int i = 0; i < 4; i++) begin
        d.total[i] = total_gain(q.gain[i]);
      end
    end
    // a write in the apply cycle keeps the flag set for the next frame
    d.update_pending = (q.update_pending && !apply_now) || gain_written;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      for (int i = 0; i < 4; i++) begin
        q.gain[i] <= `AGC_GAIN_RESET;
        q.applied[i] <= `AGC_GAIN_RESET;
        q.total[i] <= total_gain(`AGC_GAIN_RESET);
      end
      q.immediate_apply <= `AGC_CONTROL_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign applied_gain_word = q.applied;
  assign analog_gain_x1024 = q.total;
  assign update_pending = q.update_pending;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_dig
      assign digital_multiplier[g] = q.applied[g][`AGC_DIG_HI:`AGC_DIG_LO];
    end
  endgenerate

endmodule // agc_top

// File: tb/agc_properties.sv
// concurrent checks on the ports of the analog gain control block
`timescale 1ns/1ns
`include "agc_defs.svh"
module agc_properties
  import agc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic frame_start,
  input wire logic [3:0][15:0] applied_gain_word,
  input wire logic [3:0][3:0] digital_multiplier,
  input wire logic [3:0][15:0] analog_gain_x1024,
  input wire logic update_pending
);
  // ----------------------------------------
  // gain decode and properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  function automatic logic [15:0] tot(input logic [15:0] w);
    logic [15:0] c;
    logic [15:0] s;
    c = (w[11:10] == 2'b01) ? 16'h0003 : (w[11:10] == 2'b10) ? 16'h0002 : (w[11:10] == 2'b11) ? 16'h0004 : 16'h0001;
    s = (w[9:8] == 2'b01) ? 16'h002a : (w[9:8] == 2'b10) ? 16'h0040 : (w[9:8] == 2'b11) ? 16'h0080 : 16'h0020;
    return c * s * {9'h000, w[6:0]};
  endfunction

  // no bus traffic that could re-arm the pending flag
  sequence s_quiet;
    !s_axi_awvalid && !s_axi_wvalid;
  endsequence
  sequence s_frame_edge;
    update_pending && $rose(frame_start) && s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid;
  endsequence

  property p_cap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == `AGC_OFS_CAPABILITY |=> s_axi_rdata == 32'h0000_0001;
  endproperty
  a_cap: assert property (p_cap) else $error("capability read not one");
  property p_rd_global;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] == `AGC_OFS_ALL_COLOR && !update_pending
      && s_axi_awready && s_axi_wready |=> s_axi_rdata == {16'h0000, applied_gain_word[0]};
  endproperty
  a_rd_global: assert property (p_rd_global) else $error("all colour read differs");
  property p_rsvd_rd;
    s_axi_rvalid |-> !s_axi_rdata[7];
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd) else $error("reserved bit read high");
  property p_rsvd_ap;
    !(applied_gain_word[0][7] | applied_gain_word[1][7] | applied_gain_word[2][7] | applied_gain_word[3][7]);
  endproperty
  a_rsvd_ap: assert property (p_rsvd_ap) else $error("reserved bit applied");
  property p_dig;
    digital_multiplier[0] == applied_gain_word[0][15:12] && digital_multiplier[3] == applied_gain_word[3][15:12];
  endproperty
  a_dig: assert property (p_dig) else $error("digital multiplier mismatch");
  property p_total;
    $stable(applied_gain_word) |-> analog_gain_x1024[0] == tot(applied_gain_word[0])
      && analog_gain_x1024[2] == tot(applied_gain_word[2]);
  endproperty
  a_total: assert property (p_total) else $error("analog total mismatch");
  property p_frame;
    s_frame_edge ##1 s_quiet[*2] |=> !update_pending;
  endproperty
  a_frame: assert property (p_frame) else $error("frame apply late");
  property p_change;
    $changed(applied_gain_word) |-> $past(update_pending);
  endproperty
  a_change: assert property (p_change) else $error("applied without pending");
endmodule // agc_properties

// File: tb/tb_analog_gain_control.sv
// self-checking testbench for the analog gain control block
`timescale 1ns/1ns
`include "agc_defs.svh"
module tb_analog_gain_control import agc_pkg::*;;
  logic aclk = 1'b0, aresetn = 1'b0, frame_start = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, d, rd_d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, update_pending;
  logic [3:0][15:0] applied_gain_word, analog_gain_x1024;
  logic [3:0][3:0] digital_multiplier;
  int g[4] = '{default: 16'h1050};
  int ap[4] = '{default: 16'h1050};
  int cf[4] = '{1, 3, 2, 4};
  int sf[4] = '{32, 42, 64, 128};
  int pend = 0, seed = 32'hb67a, fail_count = 0, tests_run = 0;
  int napp = 0;

  agc_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_start, .applied_gain_word,
    .digital_multiplier, .analog_gain_x1024, .update_pending);

  always #5 aclk = ~aclk;

  // ----------------------------------------
  // bus tasks and comparison
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // ready is sampled mid-cycle so the release lands right after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic da;
    logic dw;
    da = 1'b0;
    dw = 1'b0;
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      da = da | s_axi_awready;
      dw = dw | s_axi_wready;
      @(posedge aclk);
      if (da) s_axi_awvalid <= 1'b0;
      if (dw) s_axi_wvalid <= 1'b0;
    end while (!(da && dw));
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    wr_r = s_axi_bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    @(posedge aclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_d, e);
  endtask
  task automatic frame();
    frame_start <= 1'b1;
    repeat (4) @(posedge aclk);
    frame_start <= 1'b0;
    repeat (2) @(posedge aclk);
    if (pend) begin
      ap = g;
      napp++;
    end
    pend = 0;
  endtask
  task automatic chk_ap();
    @(negedge aclk);
    for (int i = 0; i < 4; i++) begin
      chk(applied_gain_word[i], ap[i]);
      chk(digital_multiplier[i], ap[i][15:12]);
      chk(analog_gain_x1024[i], (cf[ap[i][11:10]] * sf[ap[i][9:8]] * ap[i][6:0]) & 16'hffff);
    end
    chk(update_pending, pend);
    @(posedge aclk);
    rchk(`AGC_OFS_STATUS, (napp << 16) | pend);
  endtask
  // all-colour write followed by a frame and a check of what was applied
  task automatic prog(input logic [15:0] w);
    wr(`AGC_OFS_ALL_COLOR, {16'h0000, w});
    g = '{default: w & 16'hff7f};
    pend = 1;
    frame();
    chk_ap();
  endtask
  task final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(`AGC_OFS_CAPABILITY, 1);
    wr(`AGC_OFS_CAPABILITY, 32'h0000_ffff);
    chk(wr_r, `AGC_RESP_OKAY);
    rchk(`AGC_OFS_CAPABILITY, 1);
    rchk(`AGC_OFS_ALL_COLOR, g[0]);
    chk_ap();
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      d[15:12] = 4'(1 + d[31:16] % 7);
      wr(8'(8 + 4 * i), d);
      g[i] = d & 16'hff7f;
      pend = 1;
    end
    for (int i = 0; i < 4; i++) rchk(8'(8 + 4 * i), g[i]);
    chk_ap();
    frame();
    chk_ap();
    // every column and second-stage code through the all-colour word
    for (int k = 0; k < 16; k++) begin
      d = $random(seed);
      d = {16'h0000, 4'(1 + k % 7), 4'(k), d[7:0]};
      wr(`AGC_OFS_ALL_COLOR, d);
      g = '{default: d & 16'hff7f};
      pend = 1;
      rchk(`AGC_OFS_ALL_COLOR, g[0]);
      frame();
      chk_ap();
    end
    // only the low byte lane is written; its bit 7 must still be dropped
    s_axi_wstrb <= 4'h1;
    wr(`AGC_OFS_RED, 32'h0000_a5bc);
    s_axi_wstrb <= 4'hf;
    g[1] = (g[1] & 16'hff00) | 16'h003c;
    pend = 1;
    rchk(`AGC_OFS_RED, g[1]);
    // programming as software is advised to: column first, fine steps on the fine field
    prog(16'h1420);
    prog(16'h1d28);
    prog(16'h1e30);
    prog(16'h1e31);
    wr(`AGC_OFS_RED, 32'h0000_1127);
    g[1] = 16'h1127;
    pend = 1;
    rchk(`AGC_OFS_ALL_COLOR, g[0]);
    frame();
    frame();
    chk_ap();
    // immediate apply: a gain write takes effect with no frame edge
    wr(`AGC_OFS_CONTROL, 32'h0000_0001);
    rchk(`AGC_OFS_CONTROL, 1);
    d = $random(seed);
    d[15:12] = 4'h3;
    wr(`AGC_OFS_GREEN_ON_BLUE, d);
    g[3] = d & 16'hff7f;
    ap = g;
    napp++;
    pend = 0;
    chk_ap();
    rd(8'h40);
    chk(rd_d, 0);
    chk(rd_r, `AGC_RESP_SLVERR);
    wr(8'h40, 32'h0000_1234);
    chk(wr_r, `AGC_RESP_SLVERR);
    final_report();
  end
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
endmodule // tb_analog_gain_control

bind agc_top agc_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .frame_start,
  .applied_gain_word, .digital_multiplier, .analog_gain_x1024, .update_pending);
